// File: verilog/rail_mon_pkg.sv
// Shared constants for the supply-rail monitor and discharge controller
`default_nettype none
package rail_mon_pkg;
	// Register bus offsets
	localparam logic [7:0] POWER_PATH_CONTROL_ADDR = 8'h1C;
	localparam logic [7:0] POWER_PATH_CONTROL_RST = 8'h60;
	localparam logic [7:0] RAIL_LIMIT_REG_ADDR = 8'h20;
	localparam logic [7:0] RAIL_LIMIT_REG_RST = 8'h00;
	localparam logic [7:0] DRAIN_STOP_L_ADDR = 8'h22;
	localparam logic [7:0] DRAIN_STOP_H_ADDR = 8'h23;
	localparam logic [7:0] ALARM_HI_L_ADDR = 8'h24;
	localparam logic [7:0] ALARM_HI_H_ADDR = 8'h25;
	localparam logic [7:0] ALARM_LO_L_ADDR = 8'h26;
	localparam logic [7:0] ALARM_LO_H_ADDR = 8'h27;
	localparam logic [7:0] STATUS_ADDR = 8'h28;
	localparam logic [7:0] FAULTS_ADDR = 8'h29;
	localparam logic [7:0] MASKS_ADDR = 8'h2A;
	localparam logic [7:0] ALERTS_ADDR = 8'h2B;
	localparam logic [7:0] REPORT_CTRL_ADDR = 8'h2C;
	localparam logic [7:0] COMMAND_ADDR = 8'h2D;
	localparam logic [7:0] CMD_ENABLE_DETECT = 8'h33;
	localparam logic [7:0] CMD_DISABLE_DETECT = 8'h22;
	// Power-path control field positions
	localparam int PPC_SAMPLING_DISABLE = 6;
	localparam int PPC_ALARM_DISABLE = 5;
	localparam int PPC_DISCONNECT_DRAIN = 4;
	localparam int PPC_FORCED_DRAIN = 2;
	localparam int PPC_VCONN_SUPPORTED = 1;
	localparam int PPC_VCONN_ENABLE = 0;
	localparam logic [7:0] PPC_WRITE_MASK = 8'h77;
	// Rail limit fields and default selector
	localparam int OV_SEL_LSB = 0;
	localparam int UV_SEL_LSB = 4;
	localparam logic [2:0] LEVEL_SEL_12P5 = 3'h0;
	// Level codes at 25 mV per step, 10 bits
	localparam logic [9:0] SAFE_ZERO_FALL_CODE = 10'h01E;
	localparam logic [9:0] SAFE_ZERO_HYST_CODE = 10'h002;
	localparam logic [9:0] PRESENT_LEVEL_CODE = 10'h0A0;
	localparam logic [9:0] DRAIN_STOP_RST = 10'h020;
	// Mask bit positions
	localparam int MSK_SAFE_ZERO = 0;
	localparam int MSK_OVERVOLT = 1;
	localparam int MSK_UNDERVOLT = 2;
	localparam int MSK_FORCED_FAIL = 3;
	localparam int MSK_DISC_FAIL = 4;
	localparam int MSK_FAULT_SUMMARY = 5;
	localparam int MSK_ALARM = 6;
	localparam logic [7:0] MASKS_RST = 8'h7F;
	// Discharge timeout
	localparam int CLK_HZ = 100_000_000;
	localparam int DRAIN_TIMEOUT_MS = 650;
	localparam int DRAIN_TIMEOUT_CYC = DRAIN_TIMEOUT_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

// File: verilog/rail_pin_sync.sv
// Three-stage input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module rail_pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// First stage feeds only the second
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change counts only when stages two and three agree
			sync_o <= (s2_q & s3_q) | (sync_o & (s2_q | s3_q));
		end
	end
endmodule // rail_pin_sync
`default_nettype wire

// File: verilog/drain_timer.sv
// Discharge timeout counter
`timescale 1ns/1ps
`default_nettype none
module drain_timer #(
	parameter int TIMEOUT_CYC = 65_000_000
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic run_i,
	output logic expired_o
);
	logic [31:0] count_q;

	// Cleared on each start, frozen once the drain stops
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			count_q <= 32'h0;
			expired_o <= 1'b0;
		end
		else if (start_i)
		begin
			count_q <= 32'h0;
			expired_o <= 1'b0;
		end
		else if (run_i && !expired_o)
		begin
			count_q <= count_q + 32'h1;
			expired_o <= (count_q == 32'(TIMEOUT_CYC - 2));
		end
	end
endmodule // drain_timer
`default_nettype wire

// File: verilog/rail_monitor.sv
// Supply-rail monitor, fault reporting and discharge control
`timescale 1ns/1ps
`default_nettype none
module rail_monitor
	import rail_mon_pkg::*;
#(
	parameter int TIMEOUT_CYC = DRAIN_TIMEOUT_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [9:0] adc_code_i,
	input wire logic adc_valid_i,
	input wire logic [9:0] ov_level_i,
	input wire logic [9:0] uv_level_i,
	input wire logic disconnect_i,
	output logic source_enable_o,
	output logic drain_on_o,
	output logic [2:0] overvoltage_level_sel_o,
	output logic [2:0] undervoltage_level_sel_o,
	output logic sampling_run_o,
	output logic alert_n_o
);
	logic [7:0] ppc_q;
	logic [7:0] limit_q;
	logic [9:0] stop_q;
	logic [9:0] alarm_hi_q;
	logic [9:0] alarm_lo_q;
	logic [7:0] mask_q;
	logic [1:0] report_q;
	logic detect_q;
	logic safe_zero_q;
	logic safe_zero_d1_q;
	logic present_q;
	logic [9:0] code_q;
	logic alarm_hi_flag_q;
	logic alarm_lo_flag_q;
	logic ext_alert_q;
	logic ov_fault_q;
	logic uv_flag_q;
	logic vendor_alert_q;
	logic forced_fail_q;
	logic disc_fail_q;
	logic fault_alert_q;
	logic forced_prev_q;
	logic disc_prev_q;
	logic [7:0] wmask;
	logic ov_event;
	logic uv_event;
	logic forced_rise;
	logic disc_rise;
	logic at_stop;
	logic timer_start;
	logic timer_expired;
	logic disc_sync;
	logic alarms_on;
	logic sz_change;

	typedef enum logic [3:0] {
		DR_IDLE = 4'b0001,
		DR_FORCED = 4'b0010,
		DR_DISC = 4'b0100,
		DR_OVER = 4'b1000
	} drain_state_e;
	drain_state_e drain_q;

	rail_pin_sync #(.WIDTH(1)) u_disc_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.async_i(disconnect_i),
		.sync_o(disc_sync)
	);

	// Write-one-to-clear mask for the sticky registers
	assign wmask = reg_wdata_i;
	assign alarms_on = !ppc_q[PPC_ALARM_DISABLE] && !ppc_q[PPC_SAMPLING_DISABLE];
	assign ov_event = adc_valid_i && (adc_code_i > ov_level_i);
	assign uv_event = adc_valid_i && (adc_code_i < uv_level_i);
	assign at_stop = code_q <= stop_q;
	assign forced_rise = ppc_q[PPC_FORCED_DRAIN] && !forced_prev_q;
	assign disc_rise = disc_sync && !disc_prev_q && ppc_q[PPC_DISCONNECT_DRAIN];
	assign sz_change = safe_zero_q != safe_zero_d1_q;
	assign timer_start = (drain_q == DR_IDLE) && (forced_rise || disc_rise || ov_event);

	drain_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.start_i(timer_start),
		.run_i(drain_q != DR_IDLE),
		.expired_o(timer_expired)
	);

	// Control registers written by the manager
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ppc_q <= POWER_PATH_CONTROL_RST;
			limit_q <= RAIL_LIMIT_REG_RST;
			stop_q <= DRAIN_STOP_RST;
			alarm_hi_q <= 10'h3FF;
			alarm_lo_q <= 10'h000;
			mask_q <= MASKS_RST;
			report_q <= 2'h1;
		end
		else if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				POWER_PATH_CONTROL_ADDR: ppc_q <= reg_wdata_i & PPC_WRITE_MASK;
				RAIL_LIMIT_REG_ADDR: limit_q <= reg_wdata_i & 8'h77;
				DRAIN_STOP_L_ADDR: stop_q[7:0] <= reg_wdata_i;
				DRAIN_STOP_H_ADDR: stop_q[9:8] <= reg_wdata_i[1:0];
				ALARM_HI_L_ADDR: alarm_hi_q[7:0] <= reg_wdata_i;
				ALARM_HI_H_ADDR: alarm_hi_q[9:8] <= reg_wdata_i[1:0];
				ALARM_LO_L_ADDR: alarm_lo_q[7:0] <= reg_wdata_i;
				ALARM_LO_H_ADDR: alarm_lo_q[9:8] <= reg_wdata_i[1:0];
				MASKS_ADDR: mask_q <= reg_wdata_i & 8'h7F;
				REPORT_CTRL_ADDR: report_q <= reg_wdata_i[1:0];
				default: ;
			endcase
		end
	end

	// Detection commands; command shares no storage
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			detect_q <= 1'b0;
		else if (reg_wr_i && reg_addr_i == COMMAND_ADDR && reg_wdata_i == CMD_ENABLE_DETECT)
			detect_q <= 1'b1;
		else if (reg_wr_i && reg_addr_i == COMMAND_ADDR && reg_wdata_i == CMD_DISABLE_DETECT)
			detect_q <= 1'b0;
	end

	// Latest sample; safe-zero comparator with hysteresis, presence comparator without
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			code_q <= 10'h3FF;
			safe_zero_q <= 1'b0;
			safe_zero_d1_q <= 1'b0;
			present_q <= 1'b0;
		end
		else
		begin
			safe_zero_d1_q <= safe_zero_q;
			if (adc_valid_i)
				code_q <= adc_code_i;
			if (!detect_q)
			begin
				safe_zero_q <= 1'b0;
				present_q <= 1'b0;
			end
			else if (adc_valid_i)
			begin
				// Falls at 0.75V, releases 50mV higher
				if (adc_code_i <= SAFE_ZERO_FALL_CODE)
					safe_zero_q <= 1'b1;
				else if (adc_code_i > SAFE_ZERO_FALL_CODE + SAFE_ZERO_HYST_CODE)
					safe_zero_q <= 1'b0;
				present_q <= adc_code_i > PRESENT_LEVEL_CODE;
			end
		end
	end

	// Sticky flags: a set wins over a same-cycle clear
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			alarm_hi_flag_q <= 1'b0;
			alarm_lo_flag_q <= 1'b0;
			ext_alert_q <= 1'b0;
			ov_fault_q <= 1'b0;
			uv_flag_q <= 1'b0;
			vendor_alert_q <= 1'b0;
			forced_fail_q <= 1'b0;
			disc_fail_q <= 1'b0;
			fault_alert_q <= 1'b0;
		end
		else
		begin
			if (alarms_on && adc_valid_i && adc_code_i > alarm_hi_q)
				alarm_hi_flag_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == FAULTS_ADDR && wmask[6])
				alarm_hi_flag_q <= 1'b0;
			if (alarms_on && adc_valid_i && adc_code_i < alarm_lo_q)
				alarm_lo_flag_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == FAULTS_ADDR && wmask[7])
				alarm_lo_flag_q <= 1'b0;
			if (sz_change && mask_q[MSK_SAFE_ZERO])
				ext_alert_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == ALERTS_ADDR && wmask[0])
				ext_alert_q <= 1'b0;
			if (ov_event && report_q[0])
				ov_fault_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == FAULTS_ADDR && wmask[0])
				ov_fault_q <= 1'b0;
			if (uv_event)
				uv_flag_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == FAULTS_ADDR && wmask[1])
				uv_flag_q <= 1'b0;
			if (uv_event && mask_q[MSK_UNDERVOLT])
				vendor_alert_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == ALERTS_ADDR && wmask[2])
				vendor_alert_q <= 1'b0;
			if (drain_q == DR_FORCED && timer_expired)
				forced_fail_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == FAULTS_ADDR && wmask[2])
				forced_fail_q <= 1'b0;
			if (drain_q == DR_DISC && timer_expired)
				disc_fail_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == FAULTS_ADDR && wmask[3])
				disc_fail_q <= 1'b0;
			if ((ov_event && report_q[0] && mask_q[MSK_OVERVOLT]) ||
				(drain_q == DR_FORCED && timer_expired && mask_q[MSK_FORCED_FAIL]) ||
				(drain_q == DR_DISC && timer_expired && mask_q[MSK_DISC_FAIL]))
				fault_alert_q <= 1'b1;
			else if (reg_wr_i && reg_addr_i == ALERTS_ADDR && wmask[1])
				fault_alert_q <= 1'b0;
		end
	end

	// Edge history for the forced-drain enable and disconnect
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			forced_prev_q <= 1'b0;
			disc_prev_q <= 1'b0;
		end
		else
		begin
			forced_prev_q <= ppc_q[PPC_FORCED_DRAIN];
			disc_prev_q <= disc_sync;
		end
	end

	// Drain sequencer; overvoltage takes priority when idle
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			drain_q <= DR_IDLE;
		else
		begin
			unique case (drain_q)
				DR_IDLE:
					if (ov_event)
						drain_q <= DR_OVER;
					else if (forced_rise)
						drain_q <= DR_FORCED;
					else if (disc_rise)
						drain_q <= DR_DISC;
				DR_FORCED, DR_DISC, DR_OVER:
					// Stop at level or on timeout, enable bits untouched
					if (at_stop || timer_expired)
						drain_q <= DR_IDLE;
				default: drain_q <= DR_IDLE;
			endcase
		end
	end

	// Sourcing off on overvoltage or, with disconnect drain enabled, on disconnect; back on by itself once the sequencer is idle and disconnect is low
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			source_enable_o <= 1'b0;
			drain_on_o <= 1'b0;
		end
		else
		begin
			if (ov_event || disc_rise)
				source_enable_o <= 1'b0;
			else if (drain_q == DR_IDLE && !disc_sync)
				source_enable_o <= 1'b1;
			drain_on_o <= (drain_q != DR_IDLE) && !at_stop && !timer_expired;
		end
	end

	// Registered pin-side outputs; alert is active low
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			overvoltage_level_sel_o <= LEVEL_SEL_12P5;
			undervoltage_level_sel_o <= LEVEL_SEL_12P5;
			sampling_run_o <= 1'b0;
			alert_n_o <= 1'b1;
		end
		else
		begin
			overvoltage_level_sel_o <= limit_q[OV_SEL_LSB +: 3];
			undervoltage_level_sel_o <= limit_q[UV_SEL_LSB +: 3];
			sampling_run_o <= !ppc_q[PPC_SAMPLING_DISABLE];
			alert_n_o <= !((fault_alert_q && mask_q[MSK_FAULT_SUMMARY]) ||
				vendor_alert_q || ext_alert_q ||
				((alarm_hi_flag_q || alarm_lo_flag_q) && mask_q[MSK_ALARM]));
		end
	end

	// Read port, registered
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				POWER_PATH_CONTROL_ADDR: reg_rdata_o <= ppc_q;
				RAIL_LIMIT_REG_ADDR: reg_rdata_o <= limit_q;
				DRAIN_STOP_L_ADDR: reg_rdata_o <= stop_q[7:0];
				DRAIN_STOP_H_ADDR: reg_rdata_o <= {6'h00, stop_q[9:8]};
				ALARM_HI_L_ADDR: reg_rdata_o <= alarm_hi_q[7:0];
				ALARM_HI_H_ADDR: reg_rdata_o <= {6'h00, alarm_hi_q[9:8]};
				ALARM_LO_L_ADDR: reg_rdata_o <= alarm_lo_q[7:0];
				ALARM_LO_H_ADDR: reg_rdata_o <= {6'h00, alarm_lo_q[9:8]};
				STATUS_ADDR: reg_rdata_o <= {4'h0, drain_q != DR_IDLE, present_q,
					detect_q, safe_zero_q};
				FAULTS_ADDR: reg_rdata_o <= {alarm_lo_flag_q, alarm_hi_flag_q, 2'h0,
					disc_fail_q, forced_fail_q, uv_flag_q, ov_fault_q};
				MASKS_ADDR: reg_rdata_o <= mask_q;
				ALERTS_ADDR: reg_rdata_o <= {5'h00, vendor_alert_q, fault_alert_q,
					ext_alert_q};
				REPORT_CTRL_ADDR: reg_rdata_o <= {6'h00, report_q};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Checks beside the logic
	property p_cmd_enable;
		@(posedge sys_clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == COMMAND_ADDR && reg_wdata_i == CMD_ENABLE_DETECT) |=> detect_q;
	endproperty
	a_cmd_enable: assert property (p_cmd_enable) else $error("enable command ignored");

	property p_cmd_disable;
		@(posedge sys_clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == COMMAND_ADDR && reg_wdata_i == CMD_DISABLE_DETECT) |=> !detect_q;
	endproperty
	a_cmd_disable: assert property (p_cmd_disable) else $error("disable command ignored");

	property p_sz_valid;
		@(posedge sys_clk_i) disable iff (rst_i)
		!detect_q |=> !safe_zero_q && !present_q;
	endproperty
	a_sz_valid: assert property (p_sz_valid) else $error("status set while not detecting");

	property p_ov_source;
		@(posedge sys_clk_i) disable iff (rst_i)
		ov_event |=> !source_enable_o;
	endproperty
	a_ov_source: assert property (p_ov_source) else $error("source on after overvoltage");

	property p_forced_start;
		@(posedge sys_clk_i) disable iff (rst_i)
		(forced_rise && drain_q == DR_IDLE && !ov_event) |=> drain_q == DR_FORCED;
	endproperty
	a_forced_start: assert property (p_forced_start) else $error("forced drain not started");

	property p_stop_keeps_enable;
		@(posedge sys_clk_i) disable iff (rst_i)
		(drain_q == DR_FORCED && at_stop && !reg_wr_i) |=> drain_q == DR_IDLE &&
			$stable(ppc_q);
	endproperty
	a_stop_keeps_enable: assert property (p_stop_keeps_enable) else $error("stop misbehaved");

	property p_forced_fail;
		@(posedge sys_clk_i) disable iff (rst_i)
		(drain_q == DR_FORCED && timer_expired) |=> forced_fail_q && drain_q == DR_IDLE;
	endproperty
	a_forced_fail: assert property (p_forced_fail) else $error("forced timeout not flagged");

	property p_disc_fail;
		@(posedge sys_clk_i) disable iff (rst_i)
		(drain_q == DR_DISC && timer_expired) |=> disc_fail_q && drain_q == DR_IDLE;
	endproperty
	a_disc_fail: assert property (p_disc_fail) else $error("disconnect timeout not flagged");

	property p_ext_alert;
		@(posedge sys_clk_i) disable iff (rst_i)
		(sz_change && mask_q[MSK_SAFE_ZERO]) |=> ext_alert_q;
	endproperty
	a_ext_alert: assert property (p_ext_alert) else $error("extended alert missed");
endmodule // rail_monitor
`default_nettype wire

// File: verification/rail_model.sv
// Rail and sampler model standing in for the analog side of the monitor
`timescale 1ns/1ps
`default_nettype none
module rail_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic drain_on_i,
	input wire logic sampling_run_i,
	output logic [9:0] adc_code_o,
	output logic adc_valid_o
);
	logic [9:0] level = 10'h000;
	logic stuck = 1'b0;
	logic [1:0] tick;
	// Bench sets the rail level and whether the drain path fails to pull it down
	task set_rail(input logic [9:0] lvl, input logic stk);
		level = lvl;
		stuck = stk;
	endtask
	// One sample every fourth cycle; the rail only moves between samples
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick <= 2'h0;
			adc_valid_o <= 1'b0;
		end
		else
		begin
			tick <= tick + 2'h1;
			adc_valid_o <= sampling_run_i && (tick == 2'h3);
			if (tick == 2'h1 && drain_on_i && !stuck)
				level <= (level > 10'h020) ? level - 10'h020 : 10'h000;
		end
	end
	// Outside a sample the code lines carry junk so stale values never pass
	assign adc_code_o = adc_valid_o ? level : ~level;
endmodule // rail_model
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the supply-rail monitor and discharge control
`timescale 1ns/1ps
`default_nettype none
module tb
	import rail_mon_pkg::*;
();
	localparam int TMO = 100;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [9:0] ov_lvl = 10'h200;
	logic [9:0] uv_lvl = 10'h000;
	logic disc = 1'b0;
	logic [7:0] rdata, v;
	logic [9:0] adc_code;
	logic adc_valid, source_en, drain_on, run, alert_n;
	logic [2:0] ov_sel, uv_sel;
	int fail_count = 0;
	int cmp_count = 0;

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	rail_monitor #(.TIMEOUT_CYC(TMO)) dut (
		.sys_clk_i(clk), .rst_i(rst), .reg_wr_i(wr_en), .reg_rd_i(rd_en),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.adc_code_i(adc_code), .adc_valid_i(adc_valid), .ov_level_i(ov_lvl),
		.uv_level_i(uv_lvl), .disconnect_i(disc), .source_enable_o(source_en),
		.drain_on_o(drain_on), .overvoltage_level_sel_o(ov_sel),
		.undervoltage_level_sel_o(uv_sel), .sampling_run_o(run), .alert_n_o(alert_n));

	rail_model rail (.sys_clk_i(clk), .rst_i(rst), .drain_on_i(drain_on),
		.sampling_run_i(run), .adc_code_o(adc_code), .adc_valid_o(adc_valid));

	// Single exit point of the run
	task automatic give_verdict;
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Strobes held through exactly one taking edge, released after it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk) #1;
		wr_en = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk) #1;
		rd_en = 1'b1;
		addr = a;
		@(posedge clk) #1;
		rd_en = 1'b0;
		v = rdata;
	endtask

	// Bounded wait for the drain path; running out ends the run
	task automatic wait_drain(input logic lvl, input int n);
		int i;
		for (i = 0; i < n && drain_on !== lvl; i++)
			@(posedge clk) #1;
		if (drain_on !== lvl)
		begin
			fail_count++;
			give_verdict;
		end
	endtask

	// Common tail of a discharge: it must start, then end early or on timeout
	task automatic drain_run(input logic stk, input int fb);
		int n;
		wait_drain(1'b1, 20);
		for (n = 0; n < 300 && drain_on === 1'b1; n++)
			@(posedge clk) #1;
		chk(drain_on, 1'b0);
		// A drain that never ends leaves nothing sound to check
		if (drain_on !== 1'b0)
			give_verdict;
		chk(n >= TMO - 10 && n <= TMO + 10, stk);
		rd(FAULTS_ADDR);
		chk(v[fb], stk);
		rd(ALERTS_ADDR);
		chk(v[1], stk);
		chk(alert_n, !stk);
		wr(FAULTS_ADDR, 8'hFF);
		wr(ALERTS_ADDR, 8'hFF);
	endtask

	task automatic t_reset_regs;
		rd(POWER_PATH_CONTROL_ADDR);
		chk(v, POWER_PATH_CONTROL_RST);
		chk(run, 1'b0);
		rd(RAIL_LIMIT_REG_ADDR);
		chk(v, 8'h00);
		chk({ov_sel, uv_sel}, {LEVEL_SEL_12P5, LEVEL_SEL_12P5});
		wr(RAIL_LIMIT_REG_ADDR, 8'h53);
		rd(RAIL_LIMIT_REG_ADDR);
		chk(v, 8'h53);
		chk({ov_sel, uv_sel}, 6'h1D);
		wr(RAIL_LIMIT_REG_ADDR, 8'h00);
		rd(8'h3F);
		chk(v, 8'h00);
		// Reserved bits 7 and 3 must not stick
		wr(POWER_PATH_CONTROL_ADDR, 8'hAB);
		rd(POWER_PATH_CONTROL_ADDR);
		chk(v, 8'h23);
		chk(run, 1'b1);
		wr(POWER_PATH_CONTROL_ADDR, 8'h00);
	endtask

	task automatic t_detect;
		rail.set_rail(10'h010, 1'b0);
		wr(COMMAND_ADDR, CMD_ENABLE_DETECT);
		repeat (12) @(posedge clk) #1;
		rd(STATUS_ADDR);
		chk(v[2:0], 3'b011);
		rail.set_rail(10'h0C0, 1'b0);
		repeat (12) @(posedge clk) #1;
		rd(STATUS_ADDR);
		chk(v[2:0], 3'b110);
		rd(ALERTS_ADDR);
		chk(v[0], 1'b1);
		wr(COMMAND_ADDR, CMD_DISABLE_DETECT);
		rd(STATUS_ADDR);
		chk(v[1], 1'b0);
		wr(ALERTS_ADDR, 8'hFF);
	endtask

	task automatic t_alarm;
		wr(ALARM_HI_L_ADDR, 8'h80);
		wr(ALARM_HI_H_ADDR, 8'h00);
		repeat (12) @(posedge clk) #1;
		rd(FAULTS_ADDR);
		chk(v[6], 1'b1);
		wr(POWER_PATH_CONTROL_ADDR, 8'h20);
		wr(FAULTS_ADDR, 8'hFF);
		repeat (12) @(posedge clk) #1;
		rd(FAULTS_ADDR);
		chk(v[6], 1'b0);
		wr(ALARM_HI_L_ADDR, 8'hFF);
		wr(ALARM_HI_H_ADDR, 8'h03);
		wr(POWER_PATH_CONTROL_ADDR, 8'h00);
		wr(FAULTS_ADDR, 8'hFF);
		wr(ALERTS_ADDR, 8'hFF);
	endtask

	task automatic t_forced;
		wr(DRAIN_STOP_L_ADDR, 8'h14);
		wr(DRAIN_STOP_H_ADDR, 8'h00);
		rail.set_rail(10'h100, 1'b0);
		wr(POWER_PATH_CONTROL_ADDR, 8'h04);
		drain_run(1'b0, 2);
		rd(POWER_PATH_CONTROL_ADDR);
		chk(v, 8'h04);
		rail.set_rail(10'h100, 1'b1);
		wr(POWER_PATH_CONTROL_ADDR, 8'h00);
		wr(POWER_PATH_CONTROL_ADDR, 8'h04);
		drain_run(1'b1, 2);
	endtask

	task automatic t_disconnect;
		wr(POWER_PATH_CONTROL_ADDR, 8'h10);
		rail.set_rail(10'h100, 1'b0);
		disc = 1'b1;
		drain_run(1'b0, 3);
		chk(source_en, 1'b0);
		rd(POWER_PATH_CONTROL_ADDR);
		chk(v, 8'h10);
		disc = 1'b0;
		repeat (8) @(posedge clk) #1;
		rail.set_rail(10'h100, 1'b1);
		disc = 1'b1;
		drain_run(1'b1, 3);
		disc = 1'b0;
	endtask

	task automatic t_overvolt;
		rail.set_rail(10'h240, 1'b0);
		wait_drain(1'b1, 20);
		chk(source_en, 1'b0);
		rd(FAULTS_ADDR);
		chk(v[0], 1'b1);
		chk(alert_n, 1'b0);
		wait_drain(1'b0, 300);
		wr(FAULTS_ADDR, 8'h01);
		wr(ALERTS_ADDR, 8'h02);
		rd(FAULTS_ADDR);
		chk(v[0], 1'b0);
		chk(alert_n, 1'b1);
		// Reporting off: the rail still drains, but nothing is flagged
		wr(REPORT_CTRL_ADDR, 8'h00);
		rail.set_rail(10'h240, 1'b0);
		wait_drain(1'b1, 20);
		chk(source_en, 1'b0);
		wait_drain(1'b0, 300);
		rd(FAULTS_ADDR);
		chk(v[0], 1'b0);
		chk(alert_n, 1'b1);
		wr(REPORT_CTRL_ADDR, 8'h01);
	endtask

	task automatic t_undervolt;
		// Masked first: flag sets, vendor alert must stay quiet
		wr(MASKS_ADDR, 8'h7B);
		rail.set_rail(10'h080, 1'b0);
		uv_lvl = 10'h100;
		repeat (12) @(posedge clk) #1;
		rd(FAULTS_ADDR);
		chk(v[1], 1'b1);
		rd(ALERTS_ADDR);
		chk(v[2], 1'b0);
		wr(MASKS_ADDR, 8'h7F);
		repeat (12) @(posedge clk) #1;
		rd(ALERTS_ADDR);
		chk(v[2], 1'b1);
		uv_lvl = 10'h000;
		wr(ALERTS_ADDR, 8'h04);
		rd(ALERTS_ADDR);
		chk(v[2], 1'b0);
	endtask

	// Main sequence: reset for 20 cycles, then each scenario in turn
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset_regs;
		t_detect;
		t_alarm;
		t_forced;
		t_disconnect;
		t_overvolt;
		t_undervolt;
		give_verdict;
	end
endmodule // tb
`default_nettype wire
